// >>> pet_regs.svh
// Constants for the externally triggered PWM channel: modes, edge codes, reset values.
// Included by the package and the design modules; definitions only.
`ifndef PET_REGS_SVH
`define PET_REGS_SVH

// Counter, duty and period width
`define PET_CNT_W        16
`define PET_CNT_ZERO     16'h0000
`define PET_CNT_ONE      16'h0001
// Reset values of the duty and period registers
`define PET_DUTY_RST     16'h0000
`define PET_PERIOD_RST   16'hFFFF

// Trigger mode {trigger_mode_hi, trigger_mode_lo}
`define PET_MODE_SW      2'h0
`define PET_MODE_LVL     2'h1
`define PET_MODE_EDGE    2'h2
`define PET_MODE_SW_CLR  2'h3

// Trigger edge {trigger_edge_hi, trigger_edge_lo}
`define PET_TG_RISE_GO   2'h1
`define PET_TG_FALL_GO   2'h2

// Emergency edge {emergency_edge_hi, emergency_edge_lo}
`define PET_EM_FALL      2'h1
`define PET_EM_RISE      2'h2
`define PET_EM_BOTH      2'h3

`endif

// >>> pet_pkg.sv
// Types of the externally triggered PWM channel.
// Assumes pet_regs.svh is on the include path.
`include "pet_regs.svh"

package pet_pkg;

    // Trigger sampler state
    typedef struct packed {
        logic s1;
        logic s2;
        logic level;
        logic rise;
        logic fall;
    } pet_filt_t;

    // Channel state
    typedef struct packed {
        logic [`PET_CNT_W-1:0] cnt;
        logic [`PET_CNT_W-1:0] duty_buf;
        logic [`PET_CNT_W-1:0] per_buf;
        logic [`PET_CNT_W-1:0] duty_reg;
        logic [`PET_CNT_W-1:0] per_reg;
        logic                  flag;
        logic                  status;
        logic                  started;
        logic                  estop;
        logic                  ch_int;
        logic                  pair_int;
    } pet_st_t;

endpackage

// >>> pet_filter.sv
// Trigger pin sampler: noise filter and edge detector.
// Assumes i_tick is a one-cycle strobe of the sampling clock.
`timescale 1ns/100ps
`include "pet_regs.svh"

module pet_filter
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // Sampling
    input  wire logic i_tick,
    input  wire logic i_pin,
    // Filtered result
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);

    pet_pkg::pet_filt_t st_q;
    pet_pkg::pet_filt_t st_d;

    // ****************************************
    // Sampling and filtering
    // ****************************************

    // Level moves only when two ticks agree, so one-tick glitches die
    always_comb
    begin
        st_d      = st_q;
        st_d.rise = 1'b0;
        st_d.fall = 1'b0;
        if (i_tick)
        begin
            st_d.s1 = i_pin;
            st_d.s2 = st_q.s1;
            if (st_q.s1 == st_q.s2 && st_q.s2 != st_q.level)
            begin
                st_d.level = st_q.s2;
                st_d.rise  = st_q.s2;
                st_d.fall  = ~st_q.s2;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign o_level = st_q.level;
    assign o_rise  = st_q.rise;
    assign o_fall  = st_q.fall;

    // Filtered level changes only after two agreeing samples
    a_filter_agree : assert property (@(posedge i_clk) disable iff (i_srst)
        (o_rise || o_fall) |-> $past(st_q.s1 == st_q.s2) && $past(i_tick))
        else $error("filtered edge without two agreeing samples");

endmodule // pet_filter

// >>> pet_top.sv
// PWM channel with external start, stop and clear and a pair emergency stop.
// Assumes i_pwm_fall strobes once per falling edge of the selected PWM clock
// and i_sample_tick once per trigger sampling clock; all inputs synchronous.
`timescale 1ns/100ps
`include "pet_regs.svh"

module pet_top
(
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    // Timing strobes
    input  wire logic                  i_pwm_fall,
    input  wire logic                  i_sample_tick,
    // External trigger pins
    input  wire logic [1:0]            i_trig_pins,
    // Channel control bits
    input  wire logic                  i_run_bit,
    input  wire logic                  i_trigger_mode_hi,
    input  wire logic                  i_trigger_mode_lo,
    input  wire logic                  i_trigger_edge_hi,
    input  wire logic                  i_trigger_edge_lo,
    input  wire logic                  i_trigger_pin_select,
    input  wire logic                  i_clear_ignore_when_high,
    // Emergency control bits
    input  wire logic                  i_coupled_mode_select,
    input  wire logic                  i_emergency_edge_hi,
    input  wire logic                  i_emergency_edge_lo,
    input  wire logic                  i_emergency_pin_select,
    input  wire logic                  i_emergency_flag_clr,
    // Register writes
    input  wire logic                  i_duty_wr,
    input  wire logic [`PET_CNT_W-1:0] i_duty_data,
    input  wire logic                  i_period_wr,
    input  wire logic [`PET_CNT_W-1:0] i_period_data,
    input  wire logic                  i_counter_wr,
    // Status and outputs
    output logic                       o_output_flag,
    output logic                       o_counting_status,
    output logic [`PET_CNT_W-1:0]      o_counter,
    output logic [`PET_CNT_W-1:0]      o_duty_buffer,
    output logic [`PET_CNT_W-1:0]      o_period_buffer,
    output logic                       o_emergency_stop_flag,
    output logic                       o_channel_interrupt,
    output logic                       o_pair_interrupt
);

    pet_pkg::pet_st_t st_q;
    pet_pkg::pet_st_t st_d;

    logic       tg_level;
    logic       tg_rise;
    logic       tg_fall;
    logic       em_rise;
    logic       em_fall;
    logic [1:0] mode;
    logic       go_lvl;
    logic       go_edge;
    logic       stop_edge;
    logic       run_go;
    logic       ext_clr;
    logic       em_evt;
    logic       quiet;

    // ****************************************
    // Trigger sampling
    // ****************************************

    // Both paths share the pins but each picks its own
    pet_filter u_tg_filt
    (
        .i_clk (i_clk), .i_srst (i_srst), .i_tick (i_sample_tick),
        .i_pin (i_trig_pins[i_trigger_pin_select]),
        .o_level (tg_level), .o_rise (tg_rise), .o_fall (tg_fall)
    );

    // Emergency path acts on edges only, so its level stays open
    pet_filter u_em_filt
    (
        .i_clk (i_clk), .i_srst (i_srst), .i_tick (i_sample_tick),
        .i_pin (i_trig_pins[i_emergency_pin_select]),
        .o_level (), .o_rise (em_rise), .o_fall (em_fall)
    );

    // ****************************************
    // Trigger decode
    // ****************************************

    assign mode = {i_trigger_mode_hi, i_trigger_mode_lo};

    // Start level / start edge / stop edge follow the edge code
    always_comb
    begin
        go_lvl    = 1'b1;
        go_edge   = 1'b0;
        stop_edge = 1'b0;
        case ({i_trigger_edge_hi, i_trigger_edge_lo})
            `PET_TG_RISE_GO:
            begin
                go_lvl    = tg_level;
                go_edge   = tg_rise;
                stop_edge = tg_fall;
            end
            `PET_TG_FALL_GO:
            begin
                go_lvl    = ~tg_level;
                go_edge   = tg_fall;
                stop_edge = tg_rise;
            end
            default: go_lvl = 1'b1;
        endcase
    end

    // Counting permission and external clear per mode
    always_comb
    begin
        run_go  = i_run_bit;
        ext_clr = 1'b0;
        case (mode)
            `PET_MODE_LVL:
            begin
                run_go  = i_run_bit & go_lvl;
                ext_clr = stop_edge;
            end
            `PET_MODE_EDGE:
            begin
                run_go  = i_run_bit & st_q.started;
                ext_clr = stop_edge & i_run_bit;
            end
            `PET_MODE_SW_CLR:
            begin
                run_go  = i_run_bit;
                // clear edge, masked while flag high
                ext_clr = stop_edge & ~(i_clear_ignore_when_high & st_q.flag);
            end
            default: ext_clr = 1'b0;
        endcase
    end

    // emergency edge only in coupled mode
    always_comb
    begin
        case ({i_emergency_edge_hi, i_emergency_edge_lo})
            `PET_EM_FALL: em_evt = em_fall;
            `PET_EM_RISE: em_evt = em_rise;
            `PET_EM_BOTH: em_evt = em_fall | em_rise;
            default:      em_evt = 1'b0;
        endcase
        em_evt = em_evt & i_coupled_mode_select;
    end

    assign quiet = ~em_evt & ~st_q.estop & ~i_counter_wr & ~ext_clr;

    // ****************************************
    // Channel state
    // ****************************************

    // Priority: emergency, counter write, external clear, counting
    always_comb
    begin
        st_d          = st_q;
        st_d.ch_int   = 1'b0;
        st_d.pair_int = 1'b0;
        // Register writes always land in the registers
        if (i_duty_wr)
            st_d.duty_reg = i_duty_data;
        if (i_period_wr)
            st_d.per_reg = i_period_data;
        if (!st_q.status && i_duty_wr)
            st_d.duty_buf = i_duty_data;
        if (!st_q.status && i_period_wr)
            st_d.per_buf = i_period_data;
        // start edge counts only with run bit
        if (mode == `PET_MODE_EDGE && go_edge && i_run_bit)
            st_d.started = 1'b1;
        if (!i_run_bit || (mode == `PET_MODE_EDGE && stop_edge))
            st_d.started = 1'b0;
        // release; a new event in the same cycle wins
        if (i_emergency_flag_clr)
            st_d.estop = 1'b0;
        if (em_evt)
        begin
            // flag, interrupt, clear, output flag and counting status off
            st_d.estop    = 1'b1;
            st_d.pair_int = 1'b1;
            st_d.cnt      = `PET_CNT_ZERO;
            st_d.status   = 1'b0;
            st_d.flag     = 1'b0;
            st_d.started  = 1'b0;
        end
        else if (st_q.estop)
        begin
            st_d.cnt    = `PET_CNT_ZERO;
            st_d.status = 1'b0;
            st_d.flag   = 1'b0;
        end
        else if (i_counter_wr)
        begin
            st_d.cnt  = `PET_CNT_ZERO;
            st_d.flag = 1'b1;
        end
        else if (ext_clr)
        begin
            // clear and reload; a stop ends counting with no tail
            st_d.cnt      = `PET_CNT_ZERO;
            st_d.flag     = 1'b1;
            st_d.status   = (mode == `PET_MODE_SW_CLR) ? st_q.status : 1'b0;
            // a write in the clear cycle lands at once, never late
            st_d.duty_buf = i_duty_wr ? i_duty_data : st_q.duty_reg;
            st_d.per_buf  = i_period_wr ? i_period_data : st_q.per_reg;
        end
        else if (i_pwm_fall)
        begin
            // status tracks permission one edge late
            st_d.status = run_go;
            if (st_q.status)
            begin
                if (st_q.cnt == st_q.per_buf)
                begin
                    st_d.cnt      = `PET_CNT_ZERO;
                    st_d.flag     = 1'b1;
                    st_d.ch_int   = 1'b1;
                    st_d.duty_buf = st_q.duty_reg;
                    st_d.per_buf  = st_q.per_reg;
                end
                else
                begin
                    st_d.cnt = st_q.cnt + `PET_CNT_ONE;
                    if (st_q.cnt == st_q.duty_buf)
                        st_d.flag = 1'b0;
                end
            end
        end
    end

    // State register; counter and flag start as after a counter write
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            st_q          <= '0;
            st_q.flag     <= 1'b1;
            st_q.duty_reg <= `PET_DUTY_RST;
            st_q.duty_buf <= `PET_DUTY_RST;
            st_q.per_reg  <= `PET_PERIOD_RST;
            st_q.per_buf  <= `PET_PERIOD_RST;
        end
        else
            st_q <= st_d;
    end

    // All outputs straight from the state register
    assign o_output_flag         = st_q.flag;
    assign o_counting_status     = st_q.status;
    assign o_counter             = st_q.cnt;
    assign o_duty_buffer         = st_q.duty_buf;
    assign o_period_buffer       = st_q.per_buf;
    assign o_emergency_stop_flag = st_q.estop;
    assign o_channel_interrupt   = st_q.ch_int;
    assign o_pair_interrupt      = st_q.pair_int;

    // ****************************************
    // Checks
    // ****************************************

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_emerg_stop_all : assert property (em_evt |=> o_emergency_stop_flag &&
        !o_output_flag && o_pair_interrupt && o_counter == `PET_CNT_ZERO && !o_counting_status)
        else $error("emergency edge did not stop the pair");
    a_estop_hold : assert property (o_emergency_stop_flag |-> !o_output_flag
        && !o_counting_status)
        else $error("outputs active while emergency flag set");
    a_estop_release : assert property (i_emergency_flag_clr && !em_evt |=>
        !o_emergency_stop_flag)
        else $error("emergency flag not released by write");
    a_ctr_write : assert property (i_counter_wr && !em_evt && !st_q.estop |=>
        o_counter == `PET_CNT_ZERO && o_output_flag)
        else $error("counter write did not zero counter");
    a_ext_clear : assert property (ext_clr && !em_evt && !st_q.estop && !i_counter_wr
        && !i_duty_wr && !i_period_wr |=> o_counter == `PET_CNT_ZERO
        && o_duty_buffer == $past(st_q.duty_reg) && o_period_buffer == $past(st_q.per_reg))
        else $error("external clear did not clear and reload");
    a_first_edge : assert property (i_pwm_fall && quiet && !o_counting_status && run_go
        |=> o_counting_status && $stable(o_counter))
        else $error("first falling edge changed count");
    a_duty_drop : assert property (i_pwm_fall && quiet && o_counting_status
        && o_counter == o_duty_buffer && o_counter != o_period_buffer |=> !o_output_flag)
        else $error("duty match did not drop flag");
    a_period_wrap : assert property (i_pwm_fall && quiet && o_counting_status
        && o_counter == o_period_buffer |=> o_counter == `PET_CNT_ZERO && o_output_flag
        && o_channel_interrupt && o_period_buffer == $past(st_q.per_reg))
        else $error("period match did not wrap and reload");
    a_run_tail : assert property (i_pwm_fall && quiet && o_counting_status && !run_go
        |=> !o_counting_status)
        else $error("counting went on past one edge after stop");
    a_edge_gate : assert property (mode == `PET_MODE_EDGE && !i_run_bit
        |=> !st_q.started)
        else $error("edge start accepted without run bit");
    a_stopped_write : assert property (i_duty_wr && !o_counting_status && quiet
        |=> o_duty_buffer == $past(i_duty_data))
        else $error("stopped duty write missed the buffer");

endmodule // pet_top

// >>> pet_trig_model.sv
// Far-side model of the PWM channel: trigger pins, PWM clock and sampling strobes.
// Assumes the bench sets the requested pin levels at the falling clock edge.
`timescale 1ns/100ps

module pet_trig_model
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // Requested pin levels
    input  wire logic [1:0] i_pin_lvl,
    // Toward the channel
    output logic [1:0]      o_trig_pins,
    output logic            o_pwm_fall,
    output logic            o_sample_tick
);
    logic div_q = 1'b0;

    // Pins are driven push-pull, so they always show the requested level
    assign o_trig_pins = i_pin_lvl;

    // paired clock source
    // PWM edge every second cycle, taken from the system clock itself
    always @(negedge i_clk)
    begin
        div_q <= i_srst ? 1'b0 : ~div_q;
    end

    // Strobes; sampling runs every cycle so a one-cycle pulse is one tick long
    assign o_pwm_fall    = div_q;
    assign o_sample_tick = ~i_srst;
endmodule // pet_trig_model

// >>> tb.sv
// Self-checking bench for the externally triggered PWM channel.
// Assumes pet_top and pet_trig_model are compiled; pins idle at the requested level.
`timescale 1ns/100ps
`include "pet_regs.svh"

module tb;
    logic clk = 1'b0, srst = 1'b1, run = 1'b0, clig = 1'b0, coupled = 1'b0, eclr = 1'b0;
    logic tsel = 1'b0, esel = 1'b1, duty_wr = 1'b0, per_wr = 1'b0, cnt_wr = 1'b0;
    logic [1:0]  mode = 2'h0, tedge = 2'h0, emode = 2'h0, lvl = 2'h3, pins;
    logic [15:0] duty_d = 16'h0000, per_d = 16'h0000, cnt_q, bufd, bufp, c0;
    logic        pwm_fall, tick, flag, stat, estop, chint, pint;
    int          n_fail = 0, checks = 0, n_pair = 0, n, m;
    logic [1:0]  st_code [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    logic        st_lvl [6]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic        st_exp [6]  = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    // Clock, 40 ns period
    always #20 clk = ~clk;

    pet_trig_model PEER (.i_clk(clk), .i_srst(srst), .i_pin_lvl(lvl), .o_trig_pins(pins),
        .o_pwm_fall(pwm_fall), .o_sample_tick(tick));

    pet_top DUT (.i_clk(clk), .i_srst(srst), .i_pwm_fall(pwm_fall), .i_sample_tick(tick),
        .i_trig_pins(pins), .i_run_bit(run), .i_trigger_mode_hi(mode[1]),
        .i_trigger_mode_lo(mode[0]), .i_trigger_edge_hi(tedge[1]), .i_trigger_edge_lo(tedge[0]),
        .i_trigger_pin_select(tsel), .i_clear_ignore_when_high(clig),
        .i_coupled_mode_select(coupled), .i_emergency_edge_hi(emode[1]),
        .i_emergency_edge_lo(emode[0]), .i_emergency_pin_select(esel),
        .i_emergency_flag_clr(eclr), .i_duty_wr(duty_wr), .i_duty_data(duty_d),
        .i_period_wr(per_wr), .i_period_data(per_d), .i_counter_wr(cnt_wr),
        .o_output_flag(flag), .o_counting_status(stat), .o_counter(cnt_q),
        .o_duty_buffer(bufd), .o_period_buffer(bufp), .o_emergency_stop_flag(estop),
        .o_channel_interrupt(chint), .o_pair_interrupt(pint));

    // Emergency interrupt pulses, counted as they pass
    always @(negedge clk)
    begin
        if (pint === 1'b1)
            n_pair++;
    end

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // Register write: duty and period together, one-cycle strobes
    task automatic regs(input logic [15:0] d, input logic [15:0] p);
        duty_d = d;
        per_d = p;
        duty_wr = 1'b1;
        per_wr = 1'b1;
        cyc(1);
        duty_wr = 1'b0;
        per_wr = 1'b0;
    endtask

    task automatic cnt_clear();
        cnt_wr = 1'b1;
        cyc(1);
        cnt_wr = 1'b0;
    endtask

    function automatic logic probe(input int s);
        case (s)
            0: probe = stat;
            1: probe = (cnt_q === 16'h0000);
            3: probe = flag;
            default: probe = chint;
        endcase
    endfunction

    // Bounded wait on one status; a timeout counts as a mismatch
    task automatic wait_on(input int s, input logic v, output int k);
        k = 0;
        while (probe(s) !== v && k < 400)
        begin
            cyc(1);
            k++;
        end
        if (k >= 400)
            check(16'h0000, 16'h0001);
    endtask

    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog, several times the expected run length
    initial
    begin
        #(40 * 8000);
        n_fail++;
        results();
    end

    // Main sequence
    initial
    begin
        cyc(6);
        srst = 1'b0;
        cyc(1);
        check(cnt_q, `PET_CNT_ZERO);
        check(flag, 1'b1);
        check(stat, 1'b0);
        check(bufd, `PET_DUTY_RST);
        check(bufp, `PET_PERIOD_RST);
        check(estop, 1'b0);
        regs(16'h0003, 16'h0007);
        cyc(1);
        check(bufd, 16'h0003);
        check(bufp, 16'h0007);
        // Software start: status first, count one PWM edge later
        run = 1'b1;
        wait_on(0, 1'b1, n);
        check(n <= 2, 1'b1);
        check(cnt_q, 16'h0000);
        wait_on(1, 1'b0, n);
        check(n <= 2, 1'b1);
        // Interrupt spacing and the duty phase after a wrap, two cycles per PWM edge
        wait_on(4, 1'b1, n);
        wait_on(4, 1'b0, n);
        wait_on(4, 1'b1, m);
        check(n + m, 16);
        wait_on(3, 1'b0, n);
        wait_on(3, 1'b1, n);
        wait_on(3, 1'b0, m);
        check(m, 8);
        // Stop with the flag low: one more count, then hold
        cyc(1);
        c0 = cnt_q;
        run = 1'b0;
        wait_on(0, 1'b0, n);
        check(cnt_q, (c0 == 16'h0007) ? 16'h0000 : c0 + 16'h0001);
        c0 = cnt_q;
        cyc(10);
        check(cnt_q, c0);
        run = 1'b1;
        wait_on(0, 1'b1, n);
        wait_on(1, 1'b0, n);
        m = 0;
        while (cnt_q === c0 && m < 8)
        begin
            cyc(1);
            m++;
        end
        check(cnt_q, (c0 == 16'h0007) ? 16'h0000 : c0 + 16'h0001);
        wait_on(3, 1'b0, n);
        run = 1'b0;
        wait_on(0, 1'b0, n);
        cnt_clear();
        check(cnt_q, 16'h0000);
        check(flag, 1'b1);
        // Edge start mode, both edge codes
        mode = `PET_MODE_EDGE;
        for (int c = 1; c <= 2; c++)
        begin
            tedge = c[1:0];
            run = 1'b0;
            lvl[0] = (c == 1) ? 1'b0 : 1'b1;
            cyc(8);
            regs(16'h0040, 16'h00FF);
            lvl[0] = ~lvl[0];
            cyc(12);
            check(stat, 1'b0);
            lvl[0] = ~lvl[0];
            cyc(8);
            run = 1'b1;
            cyc(8);
            check(stat, 1'b0);
            lvl[0] = ~lvl[0];
            cyc(1);
            lvl[0] = ~lvl[0];
            cyc(10);
            check(stat, 1'b0);
            lvl[0] = ~lvl[0];
            wait_on(0, 1'b1, n);
            cyc(20);
            regs(16'h0005, 16'h0080);
            lvl[0] = ~lvl[0];
            wait_on(0, 1'b0, n);
            check(cnt_q, 16'h0000);
            check(flag, 1'b1);
            check(bufd, 16'h0005);
            check(bufp, 16'h0080);
            // stop edge first, then software; the write made while run stays set lands at the stop
            run = 1'b0;
        end
        // Level start: high level counts, falling edge stops and clears
        mode = `PET_MODE_LVL;
        tedge = `PET_TG_RISE_GO;
        lvl[0] = 1'b0;
        cyc(8);
        run = 1'b1;
        cyc(12);
        check(stat, 1'b0);
        lvl[0] = 1'b1;
        wait_on(0, 1'b1, n);
        cyc(12);
        lvl[0] = 1'b0;
        wait_on(0, 1'b0, n);
        check(cnt_q, 16'h0000);
        check(flag, 1'b1);
        run = 1'b0;
        // Software start with external clear
        mode = `PET_MODE_SW_CLR;
        tedge = `PET_TG_RISE_GO;
        lvl[0] = 1'b1;
        clig = 1'b1;
        regs(16'h0030, 16'h003F);
        cnt_clear();
        run = 1'b1;
        wait_on(0, 1'b1, n);
        cyc(20);
        lvl[0] = 1'b0;
        cyc(10);
        check(cnt_q === 16'h0000, 1'b0);
        lvl[0] = 1'b1;
        clig = 1'b0;
        cyc(8);
        regs(16'h0020, 16'h003F);
        lvl[0] = 1'b0;
        wait_on(1, 1'b1, n);
        check(bufd, 16'h0020);
        tedge = `PET_TG_FALL_GO;
        cyc(10);
        // Writes land in the very cycle that the filtered clear edge acts
        lvl[0] = 1'b1;
        cyc(3);
        regs(16'h0010, 16'h003E);
        wait_on(1, 1'b1, n);
        check(bufd, 16'h0010);
        check(bufp, 16'h003E);
        // Emergency stop, ignored while not coupled
        mode = `PET_MODE_SW;
        emode = `PET_EM_FALL;
        lvl[1] = 1'b0;
        cyc(12);
        check(estop, 1'b0);
        lvl[1] = 1'b1;
        cyc(8);
        coupled = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            emode = st_code[i];
            m = n_pair;
            lvl[1] = st_lvl[i];
            cyc(12);
            check(estop, st_exp[i]);
            if (st_exp[i])
            begin
                check(n_pair, m + 1);
                check(cnt_q, 16'h0000);
                check(flag, 1'b0);
                eclr = 1'b1;
                cyc(1);
                eclr = 1'b0;
                cyc(2);
                check(estop, 1'b0);
            end
        end
        results();
    end
endmodule // tb
